//--- rtl/dual_timer_params.svh
// offsets, field positions, reset values and codes for the dual 16-bit timer
// assumes an APB slave with 32-bit data and byte addresses
// Function
// - config value 0x4 splits the timer into two independent 16-bit channels.
// - both channels behave identically and are configured separately.
// - one-shot/periodic is a 16-bit down-counter plus optional 8-bit prescaler.
// - timer mode field chooses one-shot or periodic counting.
// - enabled counter counts down, reloads load and prescale after 0x0000.
// - one-shot reloads and clears its enable after the 0x0000 step that follows time-out; periodic continues.
// - time-out sets sticky raw flag; masked flag and interrupt when unmasked.
// - trigger enable gives one-clock pulse when counter reaches 0x0000.
// - writing interval load reloads the counter on the next clock.
// - with stall enabled, counter holds while stall signal is asserted.
// - prescale value p makes each decrement take p+1 clocks.
// - capture-mode bit 0 with edge mode counts selected pin edges.
// - each edge decrements by one; match sets raw match flag; masked flag when unmasked.
// - at match, reload, clear enable, ignore edges until re-enabled.
// - prescaler is inactive in edge-time capture mode.
// - capture-mode bit 1 selects free-running edge-time mode from load value.
// - selected edge copies count into value register and sets capture flags.
// - edge-time counter keeps running, reloads from load value at 0x0000.
// - PWM when alternate bit 1, capture bit 0, timer mode 0x2.
// - PWM counts down, reloads after 0x0000, never sets status flags.
// - PWM asserts at load value, deasserts at match value.
// - PWM invert bit inverts the PWM output level.
`ifndef DUAL_TIMER_PARAMS_SVH
`define DUAL_TIMER_PARAMS_SVH

`define OFS_CFG 12'h000
`define OFS_MODE_A 12'h004
`define OFS_MODE_B 12'h008
`define OFS_CTRL 12'h00C
`define OFS_MASK 12'h018
`define OFS_RAW 12'h01C
`define OFS_MSK_ST 12'h020
`define OFS_CLEAR 12'h024
`define OFS_ILR_A 12'h028
`define OFS_ILR_B 12'h02C
`define OFS_MATCH_A 12'h030
`define OFS_MATCH_B 12'h034
`define OFS_PRE_A 12'h038
`define OFS_PRE_B 12'h03C
`define OFS_VAL_A 12'h048
`define OFS_VAL_B 12'h04C

`define CFG_16BIT 3'h4
`define TMR_ONESHOT 2'h1
`define TMR_PERIODIC 2'h2
`define TMR_CAPTURE 2'h3
`define EVT_RISE 2'h0
`define EVT_FALL 2'h1

`define CH_STRIDE 8
`define CTRL_WMASK 16'h6F6F
`define RST_ILR 16'hFFFF
`define RST_CNT 16'hFFFF
`define RST_PRE 8'h00
`define RST_MATCH 16'h0000

`endif

//--- rtl/dual_timer_pkg.sv
// types shared by the dual 16-bit timer
// assumes dual_timer_params.svh supplies all numbers
package dual_timer_pkg;

    typedef struct packed {
        logic ams;
        logic cmr;
        logic [1:0] tmr;
    } chan_mode_t;

    typedef struct packed {
        logic pwm_inv;
        logic ote;
        logic rsv;
        logic [1:0] evt;
        logic stall;
        logic en;
    } chan_ctrl_t;

    typedef struct packed {
        logic capture;
        logic match;
        logic timeout;
    } chan_flags_t;

    typedef enum logic [2:0] {
        FUNC_IDLE,
        FUNC_TIMER,
        FUNC_COUNT,
        FUNC_TIME,
        FUNC_PWM
    } chan_func_t;

endpackage

//--- rtl/dual_timer.sv
// dual 16-bit timer with prescaler, edge count, edge time capture and PWM
// assumes APB master on pclk; capture pins and stall request are asynchronous
`timescale 1ns/1ps
`include "dual_timer_params.svh"

module dual_timer #(
    parameter int CNT_W = 16,
    parameter int PRE_W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [1:0] ccp_in,
    input wire logic stall_req,
    output logic [1:0] trigger_out,
    output logic [1:0] pwm_out,
    output logic irq
);

    if (CNT_W != 16 || PRE_W != 8) begin : g_bad_width
        $error("dual_timer supports only a 16-bit counter with 8-bit prescaler");
    end

    // each channel owns one byte lane of the control, mask and status words
    if (`CH_STRIDE != 8) begin : g_bad_stride
        $error("dual_timer expects channel fields one byte apart");
    end

    logic [2:0] cfg_ff;
    dual_timer_pkg::chan_mode_t mode_ff [2];
    logic [15:0] ctrl_ff;
    logic [15:0] mask_ff;
    logic [15:0] raw_ff;
    logic [CNT_W-1:0] ilr_ff [2];
    logic [CNT_W-1:0] match_ff [2];
    logic [PRE_W-1:0] psr_ff [2];
    logic [CNT_W-1:0] cnt_ff [2];
    logic [PRE_W-1:0] pre_ff [2];
    logic [CNT_W-1:0] cap_ff [2];
    logic [1:0] lvl_ff;
    logic [1:0] pwm_ff;
    logic [1:0] trig_ff;
    logic irq_ff;
    logic [31:0] rdata_ff;
    logic ready_ff;
    logic err_ff;
    logic [1:0] ccp_s1_ff;
    logic [1:0] ccp_s2_ff;
    logic [1:0] ccp_d_ff;
    logic stall_s1_ff;
    logic stall_s2_ff;

    logic wr_en;
    logic active;
    logic [1:0] en_clr;
    logic [1:0] ilr_wr;
    logic [15:0] flag_set;
    logic [15:0] flag_clr;
    logic [31:0] nxt_rdata;
    logic nxt_err;

    assign prdata = rdata_ff;
    assign pready = ready_ff;
    assign pslverr = err_ff;
    assign trigger_out = trig_ff;
    assign pwm_out = pwm_ff;
    assign irq = irq_ff;

    // zero-wait decode would need a combinational prdata; one wait state keeps outputs registered
    assign wr_en = psel & penable & pwrite & ready_ff;
    assign active = (cfg_ff == `CFG_16BIT);
    assign ilr_wr[0] = wr_en & (paddr == `OFS_ILR_A);
    assign ilr_wr[1] = wr_en & (paddr == `OFS_ILR_B);
    assign flag_clr = (wr_en & (paddr == `OFS_CLEAR)) ? pwdata[15:0] : 16'h0000;

    // pins cross into pclk through two flops; the edge detector compares the second with a third, delayed flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ccp_s1_ff <= 2'h0;
            ccp_s2_ff <= 2'h0;
            ccp_d_ff <= 2'h0;
            stall_s1_ff <= 1'b0;
            stall_s2_ff <= 1'b0;
        end else begin
            ccp_s1_ff <= ccp_in;
            ccp_s2_ff <= ccp_s1_ff;
            ccp_d_ff <= ccp_s2_ff;
            stall_s1_ff <= stall_req;
            stall_s2_ff <= stall_s1_ff;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ready_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            err_ff <= 1'b0;
        end else begin
            ready_ff <= psel & penable & ~ready_ff;
            if (psel & penable & ~ready_ff) begin
                rdata_ff <= pwrite ? 32'h0000_0000 : nxt_rdata;
                err_ff <= nxt_err;
            end else begin
                rdata_ff <= 32'h0000_0000;
                err_ff <= 1'b0;
            end
        end
    end

    always_comb begin
        nxt_rdata = 32'h0000_0000;
        nxt_err = 1'b0;
        case (paddr)
            `OFS_CFG: nxt_rdata = {29'h0, cfg_ff};
            `OFS_MODE_A: nxt_rdata = {28'h0, mode_ff[0]};
            `OFS_MODE_B: nxt_rdata = {28'h0, mode_ff[1]};
            `OFS_CTRL: nxt_rdata = {16'h0, ctrl_ff};
            `OFS_MASK: nxt_rdata = {16'h0, mask_ff};
            `OFS_RAW: nxt_rdata = {16'h0, raw_ff};
            `OFS_MSK_ST: nxt_rdata = {16'h0, raw_ff & mask_ff};
            `OFS_CLEAR: nxt_rdata = 32'h0000_0000;
            `OFS_ILR_A: nxt_rdata = {16'h0, ilr_ff[0]};
            `OFS_ILR_B: nxt_rdata = {16'h0, ilr_ff[1]};
            `OFS_MATCH_A: nxt_rdata = {16'h0, match_ff[0]};
            `OFS_MATCH_B: nxt_rdata = {16'h0, match_ff[1]};
            `OFS_PRE_A: nxt_rdata = {24'h0, psr_ff[0]};
            `OFS_PRE_B: nxt_rdata = {24'h0, psr_ff[1]};
            `OFS_VAL_A: nxt_rdata = {16'h0, mode_ff[0].cmr ? cap_ff[0] : cnt_ff[0]};
            `OFS_VAL_B: nxt_rdata = {16'h0, mode_ff[1].cmr ? cap_ff[1] : cnt_ff[1]};
            default: nxt_err = 1'b1;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_ff <= 3'h0;
            mode_ff[0] <= '0;
            mode_ff[1] <= '0;
            mask_ff <= 16'h0000;
        end else if (wr_en) begin
            if (paddr == `OFS_CFG) cfg_ff <= pwdata[2:0];
            if (paddr == `OFS_MODE_A) mode_ff[0] <= pwdata[3:0];
            if (paddr == `OFS_MODE_B) mode_ff[1] <= pwdata[3:0];
            if (paddr == `OFS_MASK) mask_ff <= pwdata[15:0] & 16'h0707;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ilr_ff[0] <= `RST_ILR;
            ilr_ff[1] <= `RST_ILR;
            match_ff[0] <= `RST_MATCH;
            match_ff[1] <= `RST_MATCH;
            psr_ff[0] <= `RST_PRE;
            psr_ff[1] <= `RST_PRE;
        end else if (wr_en) begin
            if (ilr_wr[0]) ilr_ff[0] <= pwdata[15:0];
            if (ilr_wr[1]) ilr_ff[1] <= pwdata[15:0];
            if (paddr == `OFS_MATCH_A) match_ff[0] <= pwdata[15:0];
            if (paddr == `OFS_MATCH_B) match_ff[1] <= pwdata[15:0];
            if (paddr == `OFS_PRE_A) psr_ff[0] <= pwdata[7:0];
            if (paddr == `OFS_PRE_B) psr_ff[1] <= pwdata[7:0];
        end
    end

    // a software write to the control word wins over the hardware enable clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= 16'h0000;
        end else if (wr_en && paddr == `OFS_CTRL) begin
            ctrl_ff <= pwdata[15:0] & `CTRL_WMASK;
        end else begin
            ctrl_ff <= ctrl_ff & ~{7'h0, en_clr[1], 7'h0, en_clr[0]};
        end
    end

    // set wins over a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            raw_ff <= 16'h0000;
            irq_ff <= 1'b0;
        end else begin
            raw_ff <= (raw_ff & ~flag_clr) | flag_set;
            irq_ff <= |(((raw_ff & ~flag_clr) | flag_set) & mask_ff);
        end
    end

    for (genvar ch = 0; ch < 2; ch++) begin : g_ch
        dual_timer_pkg::chan_mode_t md;
        dual_timer_pkg::chan_ctrl_t ct;
        dual_timer_pkg::chan_func_t fn;
        dual_timer_pkg::chan_flags_t evt;
        logic run;
        logic rise;
        logic fall;
        logic edge_hit;
        logic tick;
        logic at_zero;
        logic wrap;
        logic [CNT_W-1:0] cnt_dec;
        logic nxt_lvl;

        assign md = mode_ff[ch];
        assign ct = ctrl_ff[ch*`CH_STRIDE +: 7];
        assign run = active & ct.en & ~(ct.stall & stall_s2_ff);
        assign rise = ccp_s2_ff[ch] & ~ccp_d_ff[ch];
        assign fall = ~ccp_s2_ff[ch] & ccp_d_ff[ch];
        assign tick = (pre_ff[ch] == {PRE_W{1'b0}});
        assign at_zero = (cnt_ff[ch] == {CNT_W{1'b0}});
        // zero lasts a whole prescaled step, so a period is (load+1)*(prescale+1) clocks
        assign wrap = tick & at_zero;
        assign cnt_dec = cnt_ff[ch] - {{(CNT_W-1){1'b0}}, 1'b1};

        always_comb begin
            case (ct.evt)
                `EVT_RISE: edge_hit = rise;
                `EVT_FALL: edge_hit = fall;
                default: edge_hit = rise | fall;
            endcase
        end

        always_comb begin
            fn = dual_timer_pkg::FUNC_IDLE;
            if (md.cmr) begin
                fn = dual_timer_pkg::FUNC_TIME;
            end else if (md.tmr == `TMR_CAPTURE) begin
                fn = dual_timer_pkg::FUNC_COUNT;
            end else if (md.ams && md.tmr == `TMR_PERIODIC) begin
                fn = dual_timer_pkg::FUNC_PWM;
            end else if (!md.ams && (md.tmr == `TMR_ONESHOT || md.tmr == `TMR_PERIODIC)) begin
                fn = dual_timer_pkg::FUNC_TIMER;
            end
        end

        assign evt.timeout = run & (fn == dual_timer_pkg::FUNC_TIMER) & tick &
                             (cnt_ff[ch] == {{(CNT_W-1){1'b0}}, 1'b1});
        assign evt.match = run & (fn == dual_timer_pkg::FUNC_COUNT) & edge_hit &
                           (cnt_dec == match_ff[ch]);
        assign evt.capture = run & (fn == dual_timer_pkg::FUNC_TIME) & edge_hit;
        assign flag_set[ch*`CH_STRIDE +: `CH_STRIDE] = {5'h0, evt};
        assign en_clr[ch] = evt.match | (run & wrap &
                            (fn == dual_timer_pkg::FUNC_TIMER) && md.tmr == `TMR_ONESHOT);

        // prescaler runs only for timer and PWM functions
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                pre_ff[ch] <= `RST_PRE;
            end else if (ilr_wr[ch]) begin
                pre_ff[ch] <= psr_ff[ch];
            end else if (run && (fn == dual_timer_pkg::FUNC_TIMER || fn == dual_timer_pkg::FUNC_PWM)) begin
                if (tick) begin
                    pre_ff[ch] <= psr_ff[ch];
                end else begin
                    pre_ff[ch] <= pre_ff[ch] - {{(PRE_W-1){1'b0}}, 1'b1};
                end
            end
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                cnt_ff[ch] <= `RST_CNT;
            end else if (ilr_wr[ch]) begin
                cnt_ff[ch] <= pwdata[CNT_W-1:0];
            end else if (run) begin
                case (fn)
                    dual_timer_pkg::FUNC_TIMER,
                    dual_timer_pkg::FUNC_PWM: begin
                        if (wrap) begin
                            cnt_ff[ch] <= ilr_ff[ch];
                        end else if (tick) begin
                            cnt_ff[ch] <= cnt_dec;
                        end
                    end
                    dual_timer_pkg::FUNC_COUNT: begin
                        if (evt.match) begin
                            cnt_ff[ch] <= ilr_ff[ch];
                        end else if (edge_hit) begin
                            cnt_ff[ch] <= cnt_dec;
                        end
                    end
                    dual_timer_pkg::FUNC_TIME: begin
                        // no prescaler here
                        cnt_ff[ch] <= at_zero ? ilr_ff[ch] : cnt_dec;
                    end
                    default: cnt_ff[ch] <= cnt_ff[ch];
                endcase
            end
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                cap_ff[ch] <= `RST_CNT;
            end else if (evt.capture) begin
                cap_ff[ch] <= cnt_ff[ch];
            end
        end

        // trigger marks only the first cycle of the zero state, even with a prescaler
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                trig_ff[ch] <= 1'b0;
            end else begin
                trig_ff[ch] <= ct.ote & evt.timeout;
            end
        end

        always_comb begin
            nxt_lvl = lvl_ff[ch];
            if (!(active && ct.en && fn == dual_timer_pkg::FUNC_PWM)) begin
                nxt_lvl = 1'b0;
            end else if (cnt_ff[ch] == ilr_ff[ch]) begin
                nxt_lvl = 1'b1;
            end else if (cnt_ff[ch] == match_ff[ch]) begin
                nxt_lvl = 1'b0;
            end
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                lvl_ff[ch] <= 1'b0;
                pwm_ff[ch] <= 1'b0;
            end else begin
                lvl_ff[ch] <= nxt_lvl;
                pwm_ff[ch] <= nxt_lvl ^ ct.pwm_inv;
            end
        end
    end

endmodule // dual_timer

//--- sim/dual_timer_sva.sv
// port assertions for the dual 16-bit timer
// assumes a bind onto dual_timer; one clock, async reset
`timescale 1ns/1ps
module dual_timer_sva (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [1:0] ccp_in,
    input wire logic stall_req,
    input wire logic [1:0] trigger_out,
    input wire logic [1:0] pwm_out,
    input wire logic irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_wait; psel && penable && !pready |=> pready; endproperty
    a_wait: assert property (p_wait) else $error("access not answered");
    property p_cause; pready |-> $past(psel && penable); endproperty
    a_cause: assert property (p_cause) else $error("ready without access");
    property p_once; pready |=> !pready; endproperty
    a_once: assert property (p_once) else $error("ready held too long");
    property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
    a_err: assert property (p_err) else $error("bad error response");
    property p_unmap; pready && paddr > 12'h04C |-> pslverr; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped access accepted");
    property p_idle; !pready || pwrite |-> prdata == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("read data outside read");
    property p_trig_a; trigger_out[0] |=> !trigger_out[0]; endproperty
    a_trig_a: assert property (p_trig_a) else $error("trigger a too long");
    property p_trig_b; trigger_out[1] |=> !trigger_out[1]; endproperty
    a_trig_b: assert property (p_trig_b) else $error("trigger b too long");
    c_trig: cover property ($rose(trigger_out[0]));
    c_pwm: cover property ($rose(pwm_out[0]));
    c_irq: cover property ($rose(irq));
endmodule // dual_timer_sva

//--- sim/ccp_source.sv
// edge source standing on one capture pin
// assumes go lasts one pclk cycle with count and gap held
`timescale 1ns/1ps
module ccp_source (
    input wire logic pclk,
    input wire logic go,
    input wire logic [7:0] count,
    input wire logic [7:0] gap,
    output logic pin,
    output logic busy
);
    initial begin
        pin = 1'b0;
        busy = 1'b0;
        forever begin
            @(posedge pclk);
            if (go) begin
                busy <= 1'b1;
                repeat (count) begin
                    repeat (gap) @(posedge pclk);
                    pin <= ~pin;
                end
                busy <= 1'b0;
            end
        end
    end
endmodule // ccp_source

//--- sim/dual_timer_tb.sv
// self-checking bench for the dual 16-bit timer
// assumes dual_timer, dual_timer_sva and ccp_source compiled first
`timescale 1ns/1ps
`include "dual_timer_params.svh"
module dual_timer_tb;
    logic pclk, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, stall_req = 1'b0;
    logic pready, pslverr, irq;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [1:0] ccp_in, trigger_out, pwm_out, busy, go = 2'b00;
    logic [7:0] cnt = 8'h6, gap = 8'h6;
    logic [64:0] notes[$];
    logic [64:0] n;
    int errors = 0, tests_run = 0, cyc = 0, seed = 54819, c, ld, p;
    dual_timer uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ccp_in(ccp_in), .stall_req(stall_req), .trigger_out(trigger_out), .pwm_out(pwm_out), .irq(irq));
    ccp_source src0 (.pclk(pclk), .go(go[0]), .count(cnt), .gap(gap), .pin(ccp_in[0]), .busy(busy[0]));
    ccp_source src1 (.pclk(pclk), .go(go[1]), .count(cnt), .gap(gap), .pin(ccp_in[1]), .busy(busy[1]));
    task automatic finish_test();
        if (errors == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic cmp(input logic [32:0] e, input logic [32:0] g);
        tests_run++;
        if (g !== e) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // the request stays put until pready is seen; one idle edge keeps drivers single per step
    task automatic xfer(input logic w, input logic [11:0] a, input logic [32:0] e, input logic [31:0] m);
        if (!w) notes.push_back({m, e});
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= e[31:0];
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, {1'b0, d}, 32'h0);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m = 32'h0000FFFF);
        xfer(1'b0, a, {1'b0, e}, m);
    endtask
    task automatic per(input int ch, output int k);
        while (trigger_out[ch] !== 1'b1) @(posedge pclk);
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (trigger_out[ch] !== 1'b1);
    endtask
    task automatic edges(input int ch, input int k);
        cnt <= 8'(k);
        go[ch] <= 1'b1;
        @(posedge pclk);
        go[ch] <= 1'b0;
        repeat (3) @(posedge pclk);
        while (busy[ch] === 1'b1) @(posedge pclk);
        repeat (8) @(posedge pclk);
    endtask
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    // generous ceiling: the whole sequence needs well under two thousand cycles
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            finish_test();
        end
    end
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            n = notes.pop_front();
            cmp({n[32], n[31:0] & n[64:33]}, {pslverr, prdata & n[64:33]});
        end
    end
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(`OFS_CFG, 32'h0);
        rd(`OFS_ILR_A, 32'hFFFF);
        rd(`OFS_VAL_B, 32'hFFFF);
        rd(`OFS_PRE_A, 32'h0);
        xfer(1'b0, 12'h100, {1'b1, 32'h0}, 32'hFFFFFFFF);
        wr(`OFS_CFG, 32'h4);
        ld = 2 + $unsigned($random(seed)) % 8;
        p = $unsigned($random(seed)) % 4;
        wr(`OFS_MODE_A, 32'h2);
        wr(`OFS_PRE_A, 32'(p));
        wr(`OFS_ILR_A, 32'(ld));
        wr(`OFS_MASK, 32'h1);
        wr(`OFS_CTRL, 32'h21);
        per(0, c);
        cmp(33'((ld + 1) * (p + 1)), 33'(c));
        cmp(33'h1, {32'h0, irq});
        rd(`OFS_RAW, 32'h1);
        rd(`OFS_MSK_ST, 32'h1);
        wr(`OFS_CTRL, 32'h0);
        wr(`OFS_CLEAR, 32'h707);
        rd(`OFS_RAW, 32'h0);
        cmp(33'h0, {32'h0, irq});
        wr(`OFS_PRE_A, 32'h0);
        wr(`OFS_MODE_B, 32'h1);
        wr(`OFS_ILR_B, 32'h5);
        wr(`OFS_CTRL, 32'h2100);
        while (trigger_out[1] !== 1'b1) @(posedge pclk);
        repeat (20) @(posedge pclk);
        rd(`OFS_CTRL, 32'h2000);
        rd(`OFS_VAL_B, 32'h5);
        rd(`OFS_RAW, 32'h100);
        wr(`OFS_CLEAR, 32'h707);
        wr(`OFS_MODE_A, 32'h3);
        wr(`OFS_ILR_A, 32'hA);
        wr(`OFS_MATCH_A, 32'h6);
        wr(`OFS_CTRL, 32'h9);
        edges(0, 6);
        rd(`OFS_RAW, 32'h2);
        rd(`OFS_CTRL, 32'h8);
        rd(`OFS_VAL_A, 32'hA);
        wr(`OFS_CLEAR, 32'h707);
        wr(`OFS_CTRL, 32'h5);
        edges(0, 5);
        rd(`OFS_VAL_A, 32'h8);
        rd(`OFS_RAW, 32'h0);
        wr(`OFS_MODE_B, 32'h7);
        wr(`OFS_ILR_B, 32'hFFFF);
        wr(`OFS_CTRL, 32'h100);
        edges(1, 4);
        rd(`OFS_RAW, 32'h400);
        rd(`OFS_VAL_B, 32'hF000, 32'hF000);
        wr(`OFS_CLEAR, 32'h707);
        wr(`OFS_MODE_A, 32'hA);
        wr(`OFS_ILR_A, 32'h9);
        wr(`OFS_MATCH_A, 32'h3);
        for (int i = 0; i < 2; i++) begin
            wr(`OFS_CTRL, i ? 32'h41 : 32'h1);
            repeat (25) @(posedge pclk);
            c = 0;
            repeat (10) begin
                @(posedge pclk);
                c += pwm_out[0];
            end
            cmp(i ? 33'h4 : 33'h6, 33'(c));
            cmp(33'h0, {32'h0, pwm_out[1]});
        end
        rd(`OFS_RAW, 32'h0);
        wr(`OFS_CTRL, 32'h0);
        wr(`OFS_MODE_A, 32'h2);
        wr(`OFS_ILR_A, 32'h3);
        stall_req <= 1'b1;
        wr(`OFS_CTRL, 32'h23);
        c = 0;
        repeat (30) begin
            @(posedge pclk);
            c += trigger_out[0];
        end
        cmp(33'h0, 33'(c));
        stall_req <= 1'b0;
        per(0, c);
        cmp(33'h4, 33'(c));
        finish_test();
    end
endmodule // dual_timer_tb
bind dual_timer dual_timer_sva chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ccp_in(ccp_in), .stall_req(stall_req), .trigger_out(trigger_out), .pwm_out(pwm_out), .irq(irq));
